// [rtl/spims_pkg.sv]
// Operation
// - Slave role: select pin always an input.
// - Selected slave drives MISO only if enabled.
// - Deselected slave: all pins inputs, no reception.
// - Deselect resets bit counter, drops partial byte.
// - Master, select output: plain output, no effect.
// - Master, select input low: become slave.
// - Lost master mode sets completion flag, interrupt.
// - Shift out and sample on opposite edges.
// - Four polarity/phase modes as tabulated.
// - Control bit 7 gates completion interrupt.
// - Control bit 6 enables all serial operation.
// - Control bit 5 selects LSB or MSB first.
// - Control bit 4 selects master or slave.
// - Control bit 3 sets SCK idle level.
// - Control bit 2 picks sample edge.
// - Rate bits divide clock, master only.
// - Data write starts transfer, read returns buffer.
// - Data write while busy sets collision flag.
// - Flag clears on vector or status-data sequence.
package spims_pkg;

  // ***************************************************************
  // Register map: word indices, byte address is four times index.
  // ***************************************************************
  localparam logic [5:0] IDX_CTRL = 6'h2C;  // Serial port control.
  localparam logic [5:0] IDX_STAT = 6'h2D;  // Serial port status.
  localparam logic [5:0] IDX_DATA = 6'h2E;  // Serial port data.
  localparam logic [5:0] IDX_PINS = 6'h2F;  // Pin direction and global enable.

  // ***************************************************************
  // Field positions.
  // ***************************************************************
  localparam int CTL_IE   = 7;  // Unit interrupt enable.
  localparam int CTL_EN   = 6;  // Unit enable.
  localparam int CTL_ORD  = 5;  // Bit order select, one is LSB first.
  localparam int CTL_MASTER_SELECT = 4;  // Master select.
  localparam int CTL_CLOCK_POLARITY = 3;  // Clock polarity.
  localparam int CTL_CLOCK_PHASE = 2;  // Clock phase.
  localparam int CTL_SPRH = 1;  // Rate select high.
  localparam int CTL_SPRL = 0;  // Rate select low.
  localparam int ST_FLAG  = 7;  // Transfer complete flag.
  localparam int ST_WRITE_COLLISION_FLAG  = 6;  // Write collision flag.
  localparam int ST_DBL   = 0;  // Double speed.
  localparam int PIN_MOSI = 0;  // MOSI direction, one is output.
  localparam int PIN_MISO = 1;  // MISO direction.
  localparam int PIN_SCK  = 2;  // SCK direction.
  localparam int PIN_SS   = 3;  // Select direction.
  localparam int PIN_SSLV = 4;  // Select pin level when output.
  localparam int PIN_GIE  = 7;  // Global interrupt enable.

  // ***************************************************************
  // Reset values and counts.
  // ***************************************************************
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] PINS_RST  = 8'h00;
  localparam logic [7:0] PINS_WMSK = 8'h9F;  // Writable pin register bits.
  localparam logic [3:0] LAST_BIT  = 4'h7;   // Index of eighth sampled bit.
  localparam logic [4:0] LAST_EDGE = 5'h0F;  // Sixteenth SCK edge of a byte.

  // Half SCK period in system clocks, indexed by {double, high, low}.
  localparam logic [6:0] HALF_TBL [0:7] = '{7'h02, 7'h08, 7'h20, 7'h40,
                                            7'h01, 7'h04, 7'h10, 7'h20};

  // Engine states.
  typedef enum logic [2:0] {
    SPIMS_IDLE = 3'b001,  // No byte in flight.
    SPIMS_MRUN = 3'b010,  // Master shifting a byte.
    SPIMS_SSEL = 3'b100   // Slave selected by a low select pin.
  } spims_state_t;

endpackage : spims_pkg

// [rtl/spims_sync.sv]
`timescale 1ns/10ps
// Two-stage synchroniser for pin inputs.
module spims_sync #(
  parameter int         W    = 4,
  parameter logic [3:0] INIT = 4'h0
) (
  input  wire logic         clk_in,  // System clock.
  input  wire logic         rst_in,  // Synchronous reset, active high.
  input  wire logic [W-1:0] d_in,    // Asynchronous pin levels.
  output logic      [W-1:0] q_out    // Synchronised levels.
);

  logic [W-1:0] meta_r;  // First stage, read only by the second stage.

  // The first stage feeds only the second, so metastability cannot spread.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_r <= INIT[W-1:0];
      q_out  <= INIT[W-1:0];
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end

endmodule : spims_sync

// [rtl/spims_rate_div.sv]
`timescale 1ns/10ps
// Master SCK half-period generator.
module spims_rate_div (
  input  wire logic       clk_in,   // System clock.
  input  wire logic       rst_in,   // Synchronous reset, active high.
  input  wire logic       run_in,   // Master transfer in progress.
  input  wire logic [2:0] rate_in,  // {double, rate high, rate low}.
  output logic            tick_out  // One-cycle pulse per SCK half period.
);

  logic [6:0] cnt_r;                                    // Cycles into half period.
  wire  [6:0] half = spims_pkg::HALF_TBL[rate_in];      // Selected half period.
  wire        hit  = (cnt_r == half);                   // Half period reached.

  // Counting restarts while idle, so the first edge is a full half period away.
  always_ff @(posedge clk_in) begin
    if (rst_in || !run_in) begin
      cnt_r    <= 7'h01;
      tick_out <= 1'b0;
    end else begin
      cnt_r    <= hit ? 7'h01 : cnt_r + 7'h01;
      tick_out <= hit;
    end
  end

endmodule : spims_rate_div

// [rtl/spims_core.sv]
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/10ps
// Serial peripheral port, master or slave, behind an AHB-Lite slave.
module spims_core (
  input  wire logic        MCLK_IN,        // System clock, 25 MHz.
  input  wire logic        RST_IN,         // Synchronous reset, active high.
  input  wire logic        HSEL_IN,        // AHB slave select.
  input  wire logic [31:0] HADDR_IN,       // AHB address.
  input  wire logic [1:0]  HTRANS_IN,      // AHB transfer type.
  input  wire logic        HWRITE_IN,      // AHB write.
  input  wire logic [2:0]  HSIZE_IN,       // AHB size, word only.
  input  wire logic [31:0] HWDATA_IN,      // AHB write data.
  input  wire logic        HREADY_IN,      // AHB ready of the bus.
  output logic      [31:0] HRDATA_OUT,     // AHB read data.
  output logic             HREADYOUT_OUT,  // AHB slave ready.
  output logic             HRESP_OUT,      // AHB response, always OKAY.
  input  wire logic        INT_ACK_IN,     // Interrupt vector taken, pulse.
  output logic             IRQ_OUT,        // Interrupt request.
  input  wire logic        SCK_IN,         // SCK pin level.
  output logic             SCK_OUT,        // SCK drive value.
  output logic             SCK_OE_N_OUT,   // SCK enable, low drives.
  input  wire logic        MOSI_IN,        // MOSI pin level.
  output logic             MOSI_OUT,       // MOSI drive value.
  output logic             MOSI_OE_N_OUT,  // MOSI enable, low drives.
  input  wire logic        MISO_IN,        // MISO pin level.
  output logic             MISO_OUT,       // MISO drive value.
  output logic             MISO_OE_N_OUT,  // MISO enable, low drives.
  input  wire logic        SS_IN,          // Select pin level.
  output logic             SS_OUT,         // Select drive value.
  output logic             SS_OE_N_OUT     // Select enable, low drives.
);

  // ***************************************************************
  // Helper functions.
  // ***************************************************************

  // Word index hit for a byte address; upper bits must be zero.
  function automatic logic reg_hit(input logic [31:0] a, input logic [5:0] idx);
    reg_hit = (a[31:8] == 24'h000000) && (a[7:2] == idx);
  endfunction : reg_hit

  // Bit currently presented on the data line.
  function automatic logic out_bit(input logic [7:0] v, input logic lsb);
    out_bit = lsb ? v[0] : v[7];
  endfunction : out_bit

  // ***************************************************************
  // Registers and state.
  // ***************************************************************
  spims_pkg::spims_state_t state_r, state_nxt;  // Engine state.
  logic [7:0] ctrl_r, ctrl_nxt;     // Serial port control.
  logic [7:0] pins_r;               // Pin directions and global enable.
  logic       flag_r, flag_nxt;     // Transfer complete flag.
  logic       write_collision_flag_r, write_collision_flag_nxt;     // Write collision flag.
  logic       dbl_r;                // Double speed.
  logic       armed_r;              // Status read with a flag set.
  logic [7:0] tx_byte_r;            // Last byte written for sending.
  logic [7:0] sh_r, sh_nxt;         // Transmit shift register.
  logic [7:0] rx_sh_r;              // Receive shift register.
  logic [7:0] rx_buf_r;             // Receive buffer.
  logic [3:0] bitcnt_r;             // Bits sampled in this byte.
  logic [4:0] edge_r;               // Master SCK edges produced.
  logic       sck_r;                // Master SCK level.
  logic       sck_d_r;              // Previous synchronised SCK.
  logic       wr_pend_r;            // Write data phase pending.
  logic [5:0] wr_idx_r;             // Index of the pending write.
  logic [3:0] pin_s;                // Synchronised {ss, sck, mosi, miso}.
  logic       tick;                 // Master half-period pulse.
  logic [2:0] smp_dly_r;            // Master sample strobes in flight.
  logic [2:0] fin_dly_r;            // Master byte end in flight.

  // ***************************************************************
  // Pin synchronisers and rate divider.
  // ***************************************************************

  // The select pin idles high so that reset never looks like a selection.
  spims_sync #(.W(4), .INIT(4'h8)) u_sync (
    .clk_in (MCLK_IN),
    .rst_in (RST_IN),
    .d_in   ({SS_IN, SCK_IN, MOSI_IN, MISO_IN}),
    .q_out  (pin_s)
  );

  spims_rate_div u_div (
    .clk_in   (MCLK_IN),
    .rst_in   (RST_IN),
    .run_in   (state_r == spims_pkg::SPIMS_MRUN),
    .rate_in  ({dbl_r, ctrl_r[spims_pkg::CTL_SPRH], ctrl_r[spims_pkg::CTL_SPRL]}),
    .tick_out (tick)
  );

  // ***************************************************************
  // Bus decode.
  // ***************************************************************
  wire       ap_valid = HSEL_IN & HTRANS_IN[1] & HREADY_IN;  // Address phase taken.
  wire       rd       = ap_valid & ~HWRITE_IN;               // Read taken.
  wire       rd_stat  = rd & reg_hit(HADDR_IN, spims_pkg::IDX_STAT);
  wire       rd_data  = rd & reg_hit(HADDR_IN, spims_pkg::IDX_DATA);
  wire [7:0] wdat     = HWDATA_IN[7:0];                      // Narrow write data.
  wire       w_ctrl   = wr_pend_r & (wr_idx_r == spims_pkg::IDX_CTRL);
  wire       w_stat   = wr_pend_r & (wr_idx_r == spims_pkg::IDX_STAT);
  wire       w_data   = wr_pend_r & (wr_idx_r == spims_pkg::IDX_DATA);
  wire       w_pins   = wr_pend_r & (wr_idx_r == spims_pkg::IDX_PINS);
  wire       data_acc = rd_data | w_data;                    // Any data access.
  wire       flg_clr  = armed_r & data_acc;                  // Status-then-data.

  // Read multiplexer, sampled in the address phase.
  wire [7:0] rd_mux =
    reg_hit(HADDR_IN, spims_pkg::IDX_CTRL) ? ctrl_r :
    reg_hit(HADDR_IN, spims_pkg::IDX_STAT) ? {flag_r, write_collision_flag_r, 5'h00, dbl_r} :
    reg_hit(HADDR_IN, spims_pkg::IDX_DATA) ? rx_buf_r :
    reg_hit(HADDR_IN, spims_pkg::IDX_PINS) ? pins_r : 8'h00;

  // ***************************************************************
  // Engine decode.
  // ***************************************************************
  wire en    = ctrl_r[spims_pkg::CTL_EN];
  wire master_select  = ctrl_r[spims_pkg::CTL_MASTER_SELECT];
  wire clock_polarity  = ctrl_r[spims_pkg::CTL_CLOCK_POLARITY];
  wire clock_phase  = ctrl_r[spims_pkg::CTL_CLOCK_PHASE];
  wire lsb   = ctrl_r[spims_pkg::CTL_ORD];
  wire ss_s  = pin_s[3];
  wire sck_s = pin_s[2];
  wire mrun  = (state_r == spims_pkg::SPIMS_MRUN);
  wire sact  = (state_r == spims_pkg::SPIMS_SSEL);

  // A low select input while master means another master took the bus.
  // With the select pin as an output it is a plain port pin.
  wire fault = en & master_select & ~pins_r[spims_pkg::PIN_SS] & ~ss_s;

  wire busy      = mrun | (fin_dly_r != 3'h0) | (sact & (bitcnt_r != 4'h0));
  wire load      = w_data & ~busy;
  wire collision = w_data & busy;
  wire start     = load & en & master_select & ~fault & (state_r == spims_pkg::SPIMS_IDLE);

  // Slave edges come from the synchronised SCK.
  wire s_rise  = sck_s & ~sck_d_r;
  wire s_fall  = ~sck_s & sck_d_r;
  wire s_lead  = clock_polarity ? s_fall : s_rise;
  wire s_trail = clock_polarity ? s_rise : s_fall;

  // Even master edges are leading, odd ones trailing.
  wire lead  = (mrun & tick & ~edge_r[0]) | (sact & s_lead);
  wire trail = (mrun & tick & edge_r[0]) | (sact & s_trail);

  // Sample and setup on opposite edges, chosen by phase.
  wire sample  = clock_phase ? trail : lead;
  wire setup   = clock_phase ? lead : trail;
  // The registered SCK pin and the MISO synchroniser cost three clocks, so the
  // master takes its bit three clocks after its own edge, once the pin settled.
  wire m_smp   = smp_dly_r[2];
  wire rx_stb  = (sact & sample) | m_smp;
  wire rx_bit  = m_smp ? pin_s[0] : pin_s[1];
  wire rx_done = rx_stb & (bitcnt_r == spims_pkg::LAST_BIT);
  wire m_fin   = mrun & tick & (edge_r == spims_pkg::LAST_EDGE);
  wire [7:0] rx_nxt = lsb ? {rx_bit, rx_sh_r[7:1]} : {rx_sh_r[6:0], rx_bit};
  wire [7:0] sh_sft = lsb ? {1'b0, sh_r[7:1]} : {sh_r[6:0], 1'b0};

  // Completion comes from a master byte end, a slave byte or master loss.
  wire flg_set = fin_dly_r[2] | (sact & rx_done) | fault;

  // ***************************************************************
  // Next-state logic.
  // ***************************************************************

  // State moves; disable drops any byte in flight at once.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      spims_pkg::SPIMS_IDLE: begin
        if (start)
          state_nxt = spims_pkg::SPIMS_MRUN;
        else if (en && !master_select && !ss_s)  // Select low activates slave.
          state_nxt = spims_pkg::SPIMS_SSEL;
      end
      spims_pkg::SPIMS_MRUN: begin
        if (!en || fault || m_fin)
          state_nxt = spims_pkg::SPIMS_IDLE;
      end
      spims_pkg::SPIMS_SSEL: begin
        // Select high makes the slave passive and resets it.
        if (!en || master_select || ss_s)
          state_nxt = spims_pkg::SPIMS_SSEL == state_r ? spims_pkg::SPIMS_IDLE
                                                       : state_r;
      end
      default: state_nxt = spims_pkg::SPIMS_IDLE;
    endcase
  end

  // Control: hardware clearing of the master bit wins over a write.
  always_comb begin
    ctrl_nxt = w_ctrl ? wdat : ctrl_r;
    if (fault)
      ctrl_nxt[spims_pkg::CTL_MASTER_SELECT] = 1'b0;
  end

  // Flags: a set in the same cycle as a clear is kept.
  assign flag_nxt = flg_set | (flag_r & ~(INT_ACK_IN | flg_clr));
  assign write_collision_flag_nxt = collision | (write_collision_flag_r & ~flg_clr);

  // Transmit shift: load, reload when idle or after a slave byte, or shift.
  always_comb begin
    if (load)
      sh_nxt = wdat;
    else if (state_r == spims_pkg::SPIMS_IDLE || (sact && rx_done))
      sh_nxt = tx_byte_r;
    else if (setup && (mrun ? (edge_r != 5'h00) : (bitcnt_r != 4'h0)))  // First bit shown.
      sh_nxt = sh_sft;
    else
      sh_nxt = sh_r;
  end

  // ***************************************************************
  // Control and status registers.
  // ***************************************************************

  // Register file and flag storage.
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      ctrl_r    <= spims_pkg::CTRL_RST;
      pins_r    <= spims_pkg::PINS_RST;
      flag_r    <= 1'b0;
      write_collision_flag_r    <= 1'b0;
      dbl_r     <= 1'b0;
      armed_r   <= 1'b0;
      tx_byte_r <= 8'h00;
    end else begin
      ctrl_r    <= ctrl_nxt;
      pins_r    <= w_pins ? (wdat & spims_pkg::PINS_WMSK) : pins_r;
      flag_r    <= flag_nxt;
      write_collision_flag_r    <= write_collision_flag_nxt;
      dbl_r     <= w_stat ? wdat[spims_pkg::ST_DBL] : dbl_r;
      armed_r   <= rd_stat ? (flag_r | write_collision_flag_r) : (data_acc ? 1'b0 : armed_r);
      tx_byte_r <= load ? wdat : tx_byte_r;
    end
  end

  // ***************************************************************
  // Shift engine.
  // ***************************************************************

  // Idle clears the counters, so deselection drops a partial byte.
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      state_r  <= spims_pkg::SPIMS_IDLE;
      sh_r     <= 8'h00;
      rx_sh_r  <= 8'h00;
      rx_buf_r <= 8'h00;
      bitcnt_r <= 4'h0;
      edge_r   <= 5'h00;
      sck_r    <= 1'b0;
      sck_d_r  <= 1'b0;
      smp_dly_r <= 3'h0;
      fin_dly_r <= 3'h0;
    end else begin
      state_r  <= state_nxt;
      smp_dly_r <= {smp_dly_r[1:0], mrun & sample};
      fin_dly_r <= {fin_dly_r[1:0], m_fin};
      sh_r     <= sh_nxt;
      sck_d_r  <= sck_s;
      if (state_r == spims_pkg::SPIMS_IDLE && fin_dly_r == 3'h0) begin
        rx_sh_r  <= 8'h00;
        bitcnt_r <= 4'h0;
      end else if (rx_stb) begin
        rx_sh_r  <= rx_nxt;
        bitcnt_r <= rx_done ? 4'h0 : bitcnt_r + 4'h1;
      end
      rx_buf_r <= rx_done ? rx_nxt : rx_buf_r;
      edge_r   <= mrun ? edge_r + {4'h0, tick} : 5'h00;
      sck_r    <= (mrun && tick) ? ~sck_r : (mrun ? sck_r : clock_polarity);
    end
  end

  // ***************************************************************
  // Bus slave and pin outputs.
  // ***************************************************************
  wire spi_m = en & master_select;
  wire spi_s = en & ~master_select;
  wire obit  = out_bit(sh_r, lsb);

  // Zero-wait slave; writes land in the data phase, reads are registered.
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      wr_pend_r     <= 1'b0;
      wr_idx_r      <= 6'h00;
      HRDATA_OUT    <= 32'h00000000;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
    end else begin
      wr_pend_r     <= ap_valid & HWRITE_IN;
      wr_idx_r      <= (HADDR_IN[31:8] == 24'h000000) ? HADDR_IN[7:2] : 6'h00;
      HRDATA_OUT    <= rd ? {24'h000000, rd_mux} : 32'h00000000;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= 1'b0;
    end
  end

  // Pin drives; a slave only ever drives MISO, and only while selected.
  always_ff @(posedge MCLK_IN) begin
    if (RST_IN) begin
      IRQ_OUT       <= 1'b0;
      SCK_OUT       <= 1'b0;
      SCK_OE_N_OUT  <= 1'b1;
      MOSI_OUT      <= 1'b0;
      MOSI_OE_N_OUT <= 1'b1;
      MISO_OUT      <= 1'b0;
      MISO_OE_N_OUT <= 1'b1;
      SS_OUT        <= 1'b0;
      SS_OE_N_OUT   <= 1'b1;
    end else begin
      IRQ_OUT       <= flag_r & ctrl_r[spims_pkg::CTL_IE] & pins_r[spims_pkg::PIN_GIE];
      SCK_OUT       <= sck_r;
      SCK_OE_N_OUT  <= spi_s | ~pins_r[spims_pkg::PIN_SCK];
      MOSI_OUT      <= obit;
      MOSI_OE_N_OUT <= spi_s | ~pins_r[spims_pkg::PIN_MOSI];
      MISO_OUT      <= obit;
      MISO_OE_N_OUT <= spi_m | (spi_s ? ~(sact & pins_r[spims_pkg::PIN_MISO])
                                      : ~pins_r[spims_pkg::PIN_MISO]);
      SS_OUT        <= pins_r[spims_pkg::PIN_SSLV];
      SS_OE_N_OUT   <= spi_s | ~pins_r[spims_pkg::PIN_SS];
    end
  end

endmodule : spims_core

// [test/spims_core_props.sv]
`timescale 1ns/10ps
// ******************************************
// Port checks of the serial port core.
// ******************************************
module spims_core_props (
  input wire logic        MCLK_IN,
  input wire logic        RST_IN,
  input wire logic        HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0]  HTRANS_IN,
  input wire logic        HWRITE_IN,
  input wire logic        HREADY_IN,
  input wire logic [31:0] HRDATA_OUT,
  input wire logic        HREADYOUT_OUT,
  input wire logic        HRESP_OUT,
  input wire logic        INT_ACK_IN,
  input wire logic        IRQ_OUT,
  input wire logic        SCK_OE_N_OUT,
  input wire logic        MOSI_OE_N_OUT,
  input wire logic        SS_OE_N_OUT
);
  logic [2:0] quiet_r;   // Cycles since a bus request or acknowledge.
  logic [2:0] quiet_nxt; // Saturates so a long idle spell never wraps.
  wire        rd_req = HSEL_IN & HTRANS_IN[1] & ~HWRITE_IN & HREADY_IN;
  assign quiet_nxt = (HTRANS_IN[1] | INT_ACK_IN) ? 3'h0 :
                     (quiet_r == 3'h7) ? quiet_r : quiet_r + 3'h1;
  // Quiet counter register.
  always_ff @(posedge MCLK_IN) begin
    quiet_r <= RST_IN ? 3'h7 : quiet_nxt;
  end
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);
  property p_ready; HREADYOUT_OUT == 1'b1; endproperty
  a_ready: assert property (p_ready) else $error("wait state seen");
  property p_okay; HRESP_OUT == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("error response seen");
  property p_rd_idle; !$past(rd_req) |-> HRDATA_OUT == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside phase");
  property p_upper; HRDATA_OUT[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_unmap; $past(rd_req && HADDR_IN[31:8] != 24'h0) |-> HRDATA_OUT == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_rst; $past(RST_IN) |-> SCK_OE_N_OUT && MOSI_OE_N_OUT && SS_OE_N_OUT && !IRQ_OUT;
  endproperty
  a_rst: assert property (p_rst) else $error("pins driven after reset");
  property p_ack; INT_ACK_IN |-> ##2 !IRQ_OUT; endproperty
  a_ack: assert property (p_ack) else $error("request kept after vector");
  property p_irq_fall; $fell(IRQ_OUT) |-> quiet_r < 3'h4; endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("request dropped alone");
endmodule : spims_core_props
bind spims_core spims_core_props u_props (.MCLK_IN(MCLK_IN), .RST_IN(RST_IN),
  .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN),
  .HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT), .HREADYOUT_OUT(HREADYOUT_OUT),
  .HRESP_OUT(HRESP_OUT), .INT_ACK_IN(INT_ACK_IN), .IRQ_OUT(IRQ_OUT),
  .SCK_OE_N_OUT(SCK_OE_N_OUT), .MOSI_OE_N_OUT(MOSI_OE_N_OUT), .SS_OE_N_OUT(SS_OE_N_OUT));

// [test/spims_peer_model.sv]
`timescale 1ns/10ps
// ******************************************
// Behavioural slave peripheral on the link.
// ******************************************
module spims_peer_model (
  input  wire logic       sck_in,
  input  wire logic       mosi_in,
  input  wire logic       ss_n_in,
  input  wire logic       clock_polarity_in,
  input  wire logic       clock_phase_in,
  input  wire logic       lsb_in,
  input  wire logic [7:0] tx_in,
  output logic            miso_out,
  output logic      [7:0] rx_out
);
  logic [7:0] sr;          // Outgoing byte.
  int         n = 0;       // Bits sampled this frame.
  logic       last = 1'b0; // Last driven level, inverted once released.
  wire        bit_w = lsb_in ? sr[0] : sr[7];
  assign miso_out = ss_n_in ? ~last : bit_w;
  // Deselect reloads the byte and restarts the frame.
  always @(ss_n_in or tx_in) if (ss_n_in) begin
    sr = tx_in;
    n = 0;
  end
  // Sample on one edge, shift on the other; phase one skips the first setup.
  always @(sck_in) if (!ss_n_in) begin
    if (sck_in == (clock_polarity_in == clock_phase_in)) begin
      rx_out = lsb_in ? {mosi_in, rx_out[7:1]} : {rx_out[6:0], mosi_in};
      n++;
    end else if (!clock_phase_in || n > 0) sr = lsb_in ? sr >> 1 : sr << 1;
  end
  // Remember the level so the released line shows its inverse.
  always @(bit_w or ss_n_in) if (!ss_n_in) last = bit_w;
endmodule : spims_peer_model

// [test/spi_master_slave_port_tb.sv]
`timescale 1ns/10ps
// ******************************************
// Self-checking bench of the serial port.
// ******************************************
module spi_master_slave_port_tb;
  logic mclk = 1'b0, rst = 1'b1, hwrite = 1'b0, int_ack = 1'b0, ss_drv = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_seen;
  logic hready, hresp, irq, sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
  logic ss_o, ss_oe_n, miso_m, clock_polarity = 1'b0, clock_phase = 1'b0, lsb = 1'b0, dbl, ie;
  logic [7:0] tx_m = 8'h00, rx_m, d;
  logic [1:0] rate;
  logic [31:0] exp_q [$];  // Expected read data, oldest first.
  int err_count = 0, n_checks = 0, r;
  event rd_ev;
  localparam logic [31:0] A_CTRL = {24'h0, spims_pkg::IDX_CTRL, 2'h0};
  localparam logic [31:0] A_STAT = {24'h0, spims_pkg::IDX_STAT, 2'h0};
  localparam logic [31:0] A_DATA = {24'h0, spims_pkg::IDX_DATA, 2'h0};
  localparam logic [31:0] A_PINS = {24'h0, spims_pkg::IDX_PINS, 2'h0};
  // Released MISO and select fall back to the other party's drive; released SCK reads low and MOSI inverted.
  wire sck_w = sck_oe_n ? 1'b0 : sck_o;
  wire mosi_w = mosi_oe_n ? ~mosi_o : mosi_o;
  wire miso_w = miso_oe_n ? miso_m : miso_o;
  wire ss_w = ss_oe_n ? ss_drv : ss_o;
  always #20 mclk = ~mclk;
  spims_core uut (.MCLK_IN(mclk), .RST_IN(rst), .HSEL_IN(1'b1), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
    .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .INT_ACK_IN(int_ack), .IRQ_OUT(irq), .SCK_IN(sck_w), .SCK_OUT(sck_o),
    .SCK_OE_N_OUT(sck_oe_n), .MOSI_IN(mosi_w), .MOSI_OUT(mosi_o),
    .MOSI_OE_N_OUT(mosi_oe_n), .MISO_IN(miso_w), .MISO_OUT(miso_o),
    .MISO_OE_N_OUT(miso_oe_n), .SS_IN(ss_w), .SS_OUT(ss_o), .SS_OE_N_OUT(ss_oe_n));
  spims_peer_model peer (.sck_in(sck_w), .mosi_in(mosi_w), .ss_n_in(ss_w),
    .clock_polarity_in(clock_polarity), .clock_phase_in(clock_phase), .lsb_in(lsb), .tx_in(tx_m), .miso_out(miso_m),
    .rx_out(rx_m));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One single transfer; the address phase is held until ready is seen.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    htrans <= 2'h2; haddr <= a; hwrite <= w;
    n = 0;
    do begin @(posedge mclk); n++; end while (hready !== 1'b1 && n < 20);
    htrans <= 2'h0; hwdata <= wd;
    do begin @(posedge mclk); n++; end while (hready !== 1'b1 && n < 40);
    if (n >= 40) begin err_count++; print_verdict(); end
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    logic [31:0] x;
    bus(1'b1, a, wd, x);
  endtask : wr
  // Notes the expectation, then hands the seen value to the monitor.
  task automatic rdx(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] x;
    exp_q.push_back(exp);
    bus(1'b0, a, 32'h0, x);
    rd_seen = x;
    ->rd_ev;
  endtask : rdx
  always @(rd_ev) chk(rd_seen, exp_q.pop_front());
  task automatic poll();
    logic [31:0] x;
    int n;
    n = 0;
    do begin bus(1'b0, A_STAT, 32'h0, x); n++; end while (x[7] !== 1'b1 && n < 1000);
    if (n >= 1000) begin err_count++; print_verdict(); end
  endtask : poll
  initial begin
    r = $urandom(82725);
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rdx(A_CTRL, 32'h0);
    wr(32'h100, 32'hFF);
    rdx(32'h100, 32'h0);
    // Every mode and both bit orders, random rates and data, with a collision.
    for (int i = 0; i < 8; i++) begin
      tx_m = $urandom; d = $urandom; rate = $urandom; dbl = $urandom;
      ie = (i == 7); clock_polarity = i[1]; clock_phase = i[0]; lsb = i[2];
      wr(A_PINS, 32'h9D);
      wr(A_STAT, {31'h0, dbl});
      wr(A_CTRL, {24'h0, ie, 1'b1, lsb, 1'b1, clock_polarity, clock_phase, rate});
      wr(A_PINS, 32'h8D);
      wr(A_DATA, {24'h0, d});
      wr(A_DATA, {24'h0, ~d});
      rdx(A_STAT, {24'h0, 7'h20, dbl});
      poll();
      chk(irq, ie);
      rdx(A_DATA, tx_m);
      chk(rx_m, d);
      rdx(A_STAT, dbl);
      $display("transfer test %0d done", i);
    end
    // Select pulled low while master with select as input.
    wr(A_PINS, 32'h85);
    wr(A_CTRL, 32'hD0);
    ss_drv <= 1'b0;
    r = 0;
    do begin @(posedge mclk); r++; end while (irq !== 1'b1 && r < 40);
    if (r >= 40) begin err_count++; print_verdict(); end
    rdx(A_CTRL, 32'hC0);
    rdx(A_STAT, {24'h0, 7'h40, dbl});
    int_ack <= 1'b1;
    @(posedge mclk);
    int_ack <= 1'b0;
    rdx(A_STAT, dbl);
    ss_drv <= 1'b1;
    wr(A_CTRL, 32'h50);
    rdx(A_CTRL, 32'h50);
    $display("lost master test done");
    @(posedge mclk);
    print_verdict();
  end
endmodule : spi_master_slave_port_tb
